// [src/fts_defines.svh]
/*
 * Constants of the fusing temperature supervisor: register offsets,
 * field positions, reset values, service codes and timing counts.
 * Assumes a 100 MHz mclk and a converter code of one degree per step.
 */
`ifndef FTS_DEFINES_SVH
`define FTS_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FTS_OFS_CTRL   6'h00
`define FTS_OFS_STATUS 6'h04
`define FTS_OFS_ISTAT  6'h08
`define FTS_OFS_IMASK  6'h0C
`define FTS_OFS_SETP   6'h10
`define FTS_OFS_OVHT   6'h14
`define FTS_OFS_TEMP   6'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FTS_IRQ_STOP   0
`define FTS_IRQ_READY  1
`define FTS_SETP_RST   12'h096
`define FTS_OVHT_RST   12'h0AF
`define FTS_SC_SENSOR  8'h1F
`define FTS_SC_WARMUP  8'h21
`define FTS_SC_ONTIME  8'h22
`define FTS_SC_OVHT    8'h23

// ----------------------------------------
// timing
// ----------------------------------------
`define FTS_CLK_NS     10
`define FTS_TICK_NS    1000000
`define FTS_TICK_CYC   (`FTS_TICK_NS / `FTS_CLK_NS)
`define FTS_WARMUP_MS  60000
`define FTS_ONTIME_MS  30000

`endif

// [src/fts_pkg.sv]
/*
 * Types of the fusing temperature supervisor.
 * Assumes fts_defines.svh is compiled alongside.
 */
`default_nettype none
package fts_pkg;

    typedef enum logic [1:0] {
        FTS_IDLE   = 2'b00,
        FTS_WARMUP = 2'b01,
        FTS_READY  = 2'b11,
        FTS_STOP   = 2'b10
    } fts_state_t;

endpackage
`default_nettype wire

// [src/fts_supervisor.sv]
/*
 * Fusing temperature supervisor with an AXI4-Lite register slave.
 * Assumes temp_code/temp_valid come from logic on mclk and that
 * sensor_fault and lamp_power_ok are asynchronous pins.
 */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.svh"

module fts_supervisor
    import fts_pkg::*;
#(
    parameter int TICK_CYC  = `FTS_TICK_CYC,
    parameter int WARMUP_MS = `FTS_WARMUP_MS,
    parameter int ONTIME_MS = `FTS_ONTIME_MS,
    parameter int TW        = 12
) (
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic [5:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output var  logic          s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output var  logic          s_axi_wready,
    output var  logic [1:0]    s_axi_bresp,
    output var  logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [5:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output var  logic          s_axi_arready,
    output var  logic [31:0]   s_axi_rdata,
    output var  logic [1:0]    s_axi_rresp,
    output var  logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [TW-1:0] temp_code,
    input  wire logic          temp_valid,
    input  wire logic          sensor_fault,
    input  wire logic          lamp_power_ok,
    output var  logic          heater_drive_n,
    output var  logic          overheat_relay_off,
    output var  logic [7:0]    service_code,
    output var  logic          printer_stop,
    output var  logic          irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        fts_state_t    st;
        logic          en;
        logic [TW-1:0] temp;
        logic [TW-1:0] setp;
        logic [TW-1:0] ovht;
        logic [1:0]    istat;
        logic [1:0]    imask;
        logic          heat;
        logic          heat_n;
        logic          relay_off;
        logic [7:0]    code;
        logic          stop;
        logic          fuse_flt;
        logic [31:0]   pre;
        logic [31:0]   wu_ms;
        logic [31:0]   on_ms;
        logic [2:0]    flt_s;
        logic [2:0]    pwr_s;
        logic          flt;
        logic          pwr;
        logic          awrdy;
        logic          awh;
        logic [5:0]    awa;
        logic          wrdy;
        logic          wh;
        logic [31:0]   wd;
        logic [3:0]    ws;
        logic          bv;
        logic [1:0]    br;
        logic          arrdy;
        logic          rv;
        logic [31:0]   rd;
        logic [1:0]    rr;
        logic          irq;
    } fts_regs_t;

    fts_regs_t r_r;
    fts_regs_t r_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  ws);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (ws[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic        tick;
        logic        wr;
        logic        hot;
        logic [1:0]  ev;
        logic [1:0]  w1c;
        logic [31:0] m;
        r_nxt = r_r;
        ev    = 2'b00;
        w1c   = 2'b00;
        m     = 32'h0000_0000;
        tick  = (r_r.pre == 32'(TICK_CYC - 1));
        hot   = (r_r.temp >= r_r.ovht);
        wr    = r_r.awh && r_r.wh && !r_r.bv;
        // pins pass three flops; a change counts when 2nd and 3rd agree
        r_nxt.flt_s = {r_r.flt_s[1:0], sensor_fault};
        r_nxt.pwr_s = {r_r.pwr_s[1:0], lamp_power_ok};
        if (r_r.flt_s[1] == r_r.flt_s[2]) begin
            r_nxt.flt = r_r.flt_s[2];
        end
        if (r_r.pwr_s[1] == r_r.pwr_s[2]) begin
            r_nxt.pwr = r_r.pwr_s[2];
        end
        if (temp_valid) begin
            r_nxt.temp = temp_code;
        end
        r_nxt.pre = tick ? 32'h0000_0000 : r_r.pre + 32'h0000_0001;
        // --- write channel ---
        if (s_axi_awvalid && r_r.awrdy) begin
            r_nxt.awh   = 1'b1;
            r_nxt.awa   = s_axi_awaddr;
            r_nxt.awrdy = 1'b0;
        end
        if (s_axi_wvalid && r_r.wrdy) begin
            r_nxt.wh   = 1'b1;
            r_nxt.wd   = s_axi_wdata;
            r_nxt.ws   = s_axi_wstrb;
            r_nxt.wrdy = 1'b0;
        end
        if (wr) begin
            r_nxt.awh = 1'b0;
            r_nxt.wh  = 1'b0;
            r_nxt.bv  = 1'b1;
            r_nxt.br  = 2'b00;
            unique case (r_r.awa)
                `FTS_OFS_CTRL: begin
                    m = merge({31'h0, r_r.en}, r_r.wd, r_r.ws);
                    r_nxt.en = m[0];
                end
                `FTS_OFS_ISTAT: begin
                    m   = merge(32'h0, r_r.wd, r_r.ws);
                    w1c = m[1:0];
                end
                `FTS_OFS_IMASK: begin
                    m = merge({30'h0, r_r.imask}, r_r.wd, r_r.ws);
                    r_nxt.imask = m[1:0];
                end
                `FTS_OFS_SETP: begin
                    m = merge(32'(r_r.setp), r_r.wd, r_r.ws);
                    r_nxt.setp = m[TW-1:0];
                end
                `FTS_OFS_OVHT: begin
                    m = merge(32'(r_r.ovht), r_r.wd, r_r.ws);
                    r_nxt.ovht = m[TW-1:0];
                end
                `FTS_OFS_STATUS, `FTS_OFS_TEMP: r_nxt.br = 2'b00;
                default: begin
                    r_nxt.br = 2'b10;
                end
            endcase
        end
        if (r_r.bv && s_axi_bready) begin
            r_nxt.bv    = 1'b0;
            r_nxt.awrdy = 1'b1;
            r_nxt.wrdy  = 1'b1;
        end
        // --- read channel ---
        if (s_axi_arvalid && r_r.arrdy) begin
            r_nxt.arrdy = 1'b0;
            r_nxt.rv    = 1'b1;
            r_nxt.rr    = 2'b00;
            unique case (s_axi_araddr)
                `FTS_OFS_CTRL:   r_nxt.rd = {31'h0, r_r.en};
                `FTS_OFS_STATUS: r_nxt.rd = {16'h0, r_r.code, 1'b0,
                                             r_r.fuse_flt, r_r.stop,
                                             r_r.relay_off, r_r.heat,
                                             1'b0, r_r.st};
                `FTS_OFS_ISTAT:  r_nxt.rd = {30'h0, r_r.istat};
                `FTS_OFS_IMASK:  r_nxt.rd = {30'h0, r_r.imask};
                `FTS_OFS_SETP:   r_nxt.rd = 32'(r_r.setp);
                `FTS_OFS_OVHT:   r_nxt.rd = 32'(r_r.ovht);
                `FTS_OFS_TEMP:   r_nxt.rd = 32'(r_r.temp);
                default: begin
                    r_nxt.rd = 32'h0000_0000;
                    r_nxt.rr = 2'b10;
                end
            endcase
        end
        if (r_r.rv && s_axi_rready) begin
            r_nxt.rv    = 1'b0;
            r_nxt.arrdy = 1'b1;
        end
        // --- supervision ---
        r_nxt.on_ms = (r_r.heat && tick) ? r_r.on_ms + 32'h1 :
                      (r_r.heat ? r_r.on_ms : 32'h0);
        if (r_r.st == FTS_WARMUP && tick) begin
            r_nxt.wu_ms = r_r.wu_ms + 32'h1;
        end
        unique case (r_r.st)
            FTS_IDLE: begin
                r_nxt.heat  = 1'b0;
                r_nxt.wu_ms = 32'h0;
                if (r_r.en) begin
                    r_nxt.st = FTS_WARMUP;
                end
            end
            FTS_WARMUP, FTS_READY: begin
                r_nxt.heat = (r_r.temp < r_r.setp);
                if (r_r.st == FTS_WARMUP && !r_nxt.heat) begin
                    r_nxt.st  = FTS_READY;
                    ev[`FTS_IRQ_READY] = 1'b1;
                end
                if (!r_r.en) begin
                    r_nxt.st   = FTS_IDLE;
                    r_nxt.heat = 1'b0;
                end
            end
            FTS_STOP: begin
                r_nxt.heat = 1'b0;
            end
        endcase
        // stop causes in priority order; any stop is final until reset
        if (r_r.st != FTS_STOP) begin
            if (r_r.flt) begin
                r_nxt.code = `FTS_SC_SENSOR;
                r_nxt.stop = 1'b1;
            end else if (hot) begin
                r_nxt.code      = `FTS_SC_OVHT;
                r_nxt.stop      = 1'b1;
            end else if (r_r.on_ms >= 32'(ONTIME_MS)) begin
                r_nxt.code = `FTS_SC_ONTIME;
                r_nxt.stop = 1'b1;
            end else if (r_r.st == FTS_WARMUP &&
                         r_r.wu_ms >= 32'(WARMUP_MS)) begin
                r_nxt.code = `FTS_SC_WARMUP;
                r_nxt.stop = 1'b1;
            end else if (r_r.heat && !r_r.pwr && !r_r.relay_off) begin
                r_nxt.fuse_flt = 1'b1;
                r_nxt.stop     = 1'b1;
            end
            if (r_nxt.stop) begin
                r_nxt.st   = FTS_STOP;
                r_nxt.heat = 1'b0;
                ev[`FTS_IRQ_STOP] = 1'b1;
            end
        end
        if (hot) begin
            r_nxt.relay_off = 1'b1;
        end
        // set wins over write-one-to-clear
        r_nxt.istat  = (r_r.istat & ~w1c) | ev;
        r_nxt.irq    = |(r_nxt.istat & r_nxt.imask);
        r_nxt.heat_n = !r_nxt.heat;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r_r       <= '0;
            r_r.heat_n <= 1'b1;
            r_r.setp  <= `FTS_SETP_RST;
            r_r.ovht  <= `FTS_OVHT_RST;
            r_r.pwr   <= 1'b1;
            r_r.pwr_s <= 3'h7;
            r_r.awrdy <= 1'b1;
            r_r.wrdy  <= 1'b1;
            r_r.arrdy <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign heater_drive_n     = r_r.heat_n;
    assign overheat_relay_off = r_r.relay_off;
    assign service_code       = r_r.code;
    assign printer_stop       = r_r.stop;
    assign irq                = r_r.irq;
    assign s_axi_awready      = r_r.awrdy;
    assign s_axi_wready       = r_r.wrdy;
    assign s_axi_bvalid       = r_r.bv;
    assign s_axi_bresp        = r_r.br;
    assign s_axi_arready      = r_r.arrdy;
    assign s_axi_rvalid       = r_r.rv;
    assign s_axi_rdata        = r_r.rd;
    assign s_axi_rresp        = r_r.rr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_regulate;
        @(posedge mclk) disable iff (!resetn)
        (r_r.st == FTS_READY && r_nxt.st == FTS_READY)
            |=> (heater_drive_n == ($past(r_r.temp) >= $past(r_r.setp)));
    endproperty
    a_regulate: assert property (p_regulate) else $error("regulation wrong");

    property p_overheat;
        @(posedge mclk) disable iff (!resetn)
        (r_r.temp >= r_r.ovht) |=> overheat_relay_off && heater_drive_n && printer_stop;
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat not cut");

    property p_drive;
        @(posedge mclk) disable iff (!resetn)
        !heater_drive_n |-> (r_r.st == FTS_WARMUP || r_r.st == FTS_READY);
    endproperty
    a_drive: assert property (p_drive) else $error("heater on in wrong state");

    property p_relay_hold;
        @(posedge mclk) disable iff (!resetn)
        overheat_relay_off |=> overheat_relay_off && printer_stop;
    endproperty
    a_relay_hold: assert property (p_relay_hold) else $error("relay released");

    property p_sample;
        @(posedge mclk) disable iff (!resetn)
        temp_valid |=> r_r.temp == $past(temp_code);
    endproperty
    a_sample: assert property (p_sample) else $error("sample lost");

    property p_sensor;
        @(posedge mclk) disable iff (!resetn)
        (r_r.flt && !printer_stop) |=> service_code == `FTS_SC_SENSOR && printer_stop;
    endproperty
    a_sensor: assert property (p_sensor) else $error("sensor fault missed");

    property p_warmup;
        @(posedge mclk) disable iff (!resetn)
        $rose(printer_stop) && service_code == `FTS_SC_WARMUP
            |-> $past(r_r.wu_ms) >= 32'(WARMUP_MS);
    endproperty
    a_warmup: assert property (p_warmup) else $error("early warm-up stop");

    property p_ontime;
        @(posedge mclk) disable iff (!resetn)
        r_r.on_ms <= 32'(ONTIME_MS) || printer_stop;
    endproperty
    a_ontime: assert property (p_ontime) else $error("on-time overrun");

    property p_stop_hold;
        @(posedge mclk) disable iff (!resetn)
        printer_stop |=> printer_stop && heater_drive_n && $stable(service_code);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop not held");

endmodule
`default_nettype wire

// [test/fts_partner.sv]
/*
 * Model of the roller thermistor and its converter.
 * Assumes it runs on mclk; the bench may load a temperature or let the
 * roller heat and cool with the heater drive.
 */
`timescale 1ns/1ps
`default_nettype none

module fts_partner (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        heater_drive_n,
    input  wire logic        overheat_relay_off,
    input  wire logic        lamp_power_ok,
    input  wire logic        heat,
    input  wire logic        ld,
    input  wire logic [11:0] ld_val,
    output var  logic [11:0] temp_code,
    output var  logic        temp_valid
);
    logic [1:0] ph;

    // one converter sample every four cycles
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ph <= 2'h0;
            temp_valid <= 1'b0;
            temp_code <= 12'h019;
        end else begin
            ph <= ph + 2'h1;
            temp_valid <= (ph == 2'h3);
            if (ld) begin
                temp_code <= ld_val;
            end else if (heat && ph == 2'h3) begin
                if (!heater_drive_n && !overheat_relay_off && lamp_power_ok) begin
                    temp_code <= temp_code + 12'h002;
                end else begin
                    temp_code <= temp_code - 12'h001;
                end
            end
        end
    end
endmodule

`default_nettype wire

// [test/fuser_temperature_supervisor_tb.sv]
/*
 * Self-checking bench of the fusing temperature supervisor.
 * Assumes short tick and limit parameters so that timeouts fit the run.
 */
`timescale 1ns/1ps
`default_nettype none

module fuser_temperature_supervisor_tb;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [5:0]  s_axi_awaddr = 6'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [5:0]  s_axi_araddr = 6'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [11:0] temp_code;
    logic        temp_valid;
    logic        sensor_fault = 1'b0;
    logic        lamp_power_ok = 1'b1;
    logic        heater_drive_n;
    logic        overheat_relay_off;
    logic [7:0]  service_code;
    logic        printer_stop;
    logic        irq;
    logic        heat = 1'b0;
    logic        ld = 1'b0;
    logic [11:0] ld_val = 12'h0;
    logic [31:0] rdat;
    logic [1:0]  resp;
    int          bad_count = 0;
    int          compares = 0;

    always #5 mclk = ~mclk;

    fts_supervisor #(.TICK_CYC(4), .WARMUP_MS(20), .ONTIME_MS(40)) uut (
        .mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .temp_code, .temp_valid,
        .sensor_fault, .lamp_power_ok, .heater_drive_n, .overheat_relay_off,
        .service_code, .printer_stop, .irq
    );

    fts_partner sensor (
        .mclk, .resetn, .heater_drive_n, .overheat_relay_off, .lamp_power_ok,
        .heat, .ld, .ld_val, .temp_code, .temp_valid
    );

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(posedge mclk);
            if (pa && s_axi_awready) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge mclk);
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge mclk);
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic load(input logic [11:0] v);
        ld <= 1'b1;
        ld_val <= v;
        @(posedge mclk);
        ld <= 1'b0;
        cyc(12);
    endtask

    task automatic rst;
        resetn <= 1'b0;
        sensor_fault <= 1'b0;
        lamp_power_ok <= 1'b1;
        heat <= 1'b0;
        cyc(8);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        bad_count++;
        wrap_up();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [5:0]  ra [5] = '{6'h00, 6'h08, 6'h0C, 6'h10, 6'h14};
        logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h096, 32'h0AF};
        rst();
        chk("heater_rst", heater_drive_n, 1'b1);
        chk("stop_rst", printer_stop, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            chk("reg_rst", rdat, rv[i]);
        end
        rd(6'h1C);
        chk("unmapped", {resp, rdat[29:0]}, 32'h80000000);
        wr(6'h04, 32'hFFFFFFFF);
        chk("status_wr", resp, 2'b00);
        wr(6'h1C, 32'h1);
        chk("unmapped_wr", resp, 2'b10);
        rd(6'h04);
        chk("status_ro", rdat, 32'h0);
        wr(6'h0C, 32'h1);
        load(12'h064);
        wr(6'h00, 32'h1);
        cyc(12);
        chk("heat_low", heater_drive_n, 1'b0);
        rd(6'h04);
        chk("warmup", rdat[1:0], 2'b01);
        load(12'h096);
        chk("heat_set", heater_drive_n, 1'b1);
        chk("irq_mask", irq, 1'b0);
        wr(6'h0C, 32'h3);
        chk("irq_rdy", irq, 1'b1);
        wr(6'h08, 32'h2);
        chk("irq_clr", irq, 1'b0);
        load(12'h095);
        chk("heat_on", heater_drive_n, 1'b0);
        rd(6'h18);
        chk("temp", rdat, 32'h095);
        load(12'h0AF);
        chk("relay", overheat_relay_off, 1'b1);
        chk("ovht_heat", heater_drive_n, 1'b1);
        chk("ovht_code", {printer_stop, service_code}, 9'h123);
        chk("irq_stop", irq, 1'b1);
        load(12'h064);
        chk("held_heat", heater_drive_n, 1'b1);
        chk("held_code", service_code, 8'h23);

        rst();
        wr(6'h00, 32'h1);
        cyc(120);
        chk("warm_code", {printer_stop, service_code}, 9'h121);
        chk("warm_heat", heater_drive_n, 1'b1);

        rst();
        s_axi_wstrb <= 4'h1;
        wr(6'h10, 32'hFFFFFF78);
        s_axi_wstrb <= 4'hF;
        rd(6'h10);
        chk("setp_lane", rdat, 32'h078);
        load(12'h07D);
        wr(6'h00, 32'h1);
        cyc(12);
        chk("setp_cfg", heater_drive_n, 1'b1);
        load(12'h064);
        cyc(100);
        chk("on_early", service_code, 8'h0);
        cyc(70);
        chk("on_code", {printer_stop, service_code}, 9'h122);

        rst();
        heat <= 1'b1;
        load(12'h08C);
        wr(6'h00, 32'h1);
        cyc(300);
        rd(6'h18);
        chk("regulate", rdat >= 32'h093 && rdat <= 32'h099, 1'b1);
        chk("reg_run", printer_stop, 1'b0);
        wr(6'h00, 32'h0);
        cyc(4);
        chk("en_off", heater_drive_n, 1'b1);
        rd(6'h04);
        chk("idle", rdat[1:0], 2'b00);

        rst();
        wr(6'h00, 32'h1);
        sensor_fault <= 1'b1;
        cyc(12);
        chk("sensor", {printer_stop, service_code}, 9'h11F);

        rst();
        load(12'h064);
        wr(6'h00, 32'h1);
        lamp_power_ok <= 1'b0;
        cyc(12);
        chk("fuse", {printer_stop, service_code}, 9'h100);
        rd(6'h04);
        chk("fuse_flt", rdat[6:5], 2'b11);
        wrap_up();
    end
endmodule

`default_nettype wire
